//--- rtl/aerl_top.sv
// exceptional result register and converter event logic, AHB-Lite slave
// assumes sequencer strobes are one-cycle pulses on the system clock
//
// Functional notes
// - overrun set when overwriting a valid result
// - overrun only in overwrite, non-software mode
// - result read clears overrun; read only
// - valid set on update after all repeats
// - result read clears valid flag
// - read-write hold-until-read select bit
// - 8-bit result at 11:4, low zeros
// - 10-bit result at 11:2, low zeros
// - reserved result bits read as zero
// - burst request per finished sequence
// - burst request per exceptional sequence done
// - one request per channel zero to seven
// - channel request on valid, not software mode
// - exceptional sequence event sets status, interrupt
// - exceptional interrupt measurement sets status, interrupt
// - per-channel done interrupt with status bit
// - interrupt on valid, not software mode
// - status word: bits 9, 8, 7..0
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
module aerl_top
	import aerl_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	// converter sequencer
	input  wire logic                  res_wr,
	input  wire logic [AERL_RAW_W-1:0] res_raw,
	input  wire logic                  res_10bit,
	input  wire logic                  repeats_done,
	input  wire logic                  sw_mode,
	input  wire logic                  seq_done,
	input  wire logic                  xseq_done,
	input  wire logic [AERL_NCH-1:0]   ch_valid_set,
	// dma controller
	output logic                       dma_seq_burst_req,
	output logic                       dma_xseq_burst_req,
	output logic [AERL_NCH-1:0]        dma_ch_req,
	// interrupt controller
	output logic                       irq_xseq,
	output logic                       irq_xint,
	output logic [AERL_NCH-1:0]        irq_ch
);
	import aerl_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// word address match, low two bits ignored for aligned words
	function automatic logic addr_is(
		input logic [AERL_ADDR_W-1:0] a,
		input logic [AERL_ADDR_W-1:0] off);
		addr_is = (a[AERL_ADDR_W-1:2] == off[AERL_ADDR_W-1:2]);
	endfunction

	// left-justify a raw result into the value field
	function automatic logic [AERL_VAL_W-1:0] fmt_result(
		input logic [AERL_RAW_W-1:0] raw,
		input logic                  ten);
		logic [AERL_VAL_W-1:0] v;
		v = '0;
		if (ten) begin
			v = {raw, {AERL_PAD10{1'b0}}};
		end else begin
			v = {raw[AERL_RAW8_W-1:0], {AERL_PAD8{1'b0}}};
		end
		fmt_result = v;
	endfunction

	// ----------------------------------------------------------------
	// result holder
	// ----------------------------------------------------------------
	aerl_res_if rif ();                     // carrier to the holder

	aerl_result_hold u_hold (
		.clock   (clock),
		.reset_n (reset_n),
		.rif     (rif)
	);

	assign rif.hw_wr        = res_wr;
	assign rif.hw_value     = fmt_result(res_raw, res_10bit);
	assign rif.repeats_done = repeats_done;
	assign rif.sw_mode      = sw_mode;

	// ----------------------------------------------------------------
	// bus address phase
	// ----------------------------------------------------------------
	logic                   acc;        // valid word transfer accepted
	logic                   rd_acc;     // accepted read
	logic                   wr_acc;     // accepted write
	logic [AERL_ADDR_W-1:0] a_addr;     // address phase offset
	aerl_phase_t            phase_q;    // data phase kind
	logic [AERL_ADDR_W-1:0] waddr_q;    // latched write offset

	// only whole words are decoded; other sizes are ignored
	assign acc    = hsel && htrans[1] && hready && (hsize == AERL_HSIZE_WORD);
	assign rd_acc = acc && !hwrite;
	assign wr_acc = acc && hwrite;
	assign a_addr = haddr[AERL_ADDR_W-1:0];

	// data phase tracker, one state per transfer kind
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			phase_q <= AERL_PH_IDLE;
		end else if (hready) begin
			if (wr_acc) begin
				phase_q <= AERL_PH_WRITE;
			end else if (rd_acc) begin
				phase_q <= AERL_PH_READ;
			end else begin
				phase_q <= AERL_PH_IDLE;
			end
		end
	end

	// write offset held into the data phase, when hwdata arrives
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			waddr_q <= '0;
		end else if (wr_acc) begin
			waddr_q <= a_addr;
		end
	end

	// zero wait states: the slave is always ready and always okay,
	// which keeps the read side effects tied to the address phase
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			hreadyout <= 1'b1;
			hresp     <= AERL_RESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= AERL_RESP_OKAY;
		end
	end

	// ----------------------------------------------------------------
	// write data phase
	// ----------------------------------------------------------------
	logic wr_dp;          // write data phase present
	logic clr_wr;         // status clear write
	assign wr_dp  = (phase_q == AERL_PH_WRITE);
	assign clr_wr = wr_dp && addr_is(waddr_q, AERL_OFF_CLEAR);

	// hold select written in the result word; other bits are r/o
	assign rif.sel_wr  = wr_dp && addr_is(waddr_q, AERL_OFF_RESULT);
	assign rif.sel_val = hwdata[AERL_HOLD_BIT];

	// result read clears flags in the address phase
	assign rif.rd_clr = rd_acc && addr_is(a_addr, AERL_OFF_RESULT);

	// ----------------------------------------------------------------
	// event detection
	// ----------------------------------------------------------------
	logic [AERL_NCH-1:0]   ch_evt;    // qualified channel events
	logic                  xint_evt;  // exceptional result became valid
	logic [AERL_STS_W-1:0] sts_set;   // status set vector
	logic [AERL_STS_W-1:0] sts_q;     // interrupt status word

	assign ch_evt  = sw_mode ? '0 : ch_valid_set;
	// exceptional valid rise, not software mode
	assign xint_evt = rif.valid_rise && !sw_mode;

	assign sts_set = {xseq_done, xint_evt, ch_evt};

	// sticky status, set wins over a clear
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sts_q <= '0;
		end else begin
			sts_q <= sts_set |
				(sts_q & ~(clr_wr ? hwdata[AERL_STS_W-1:0] : '0));
		end
	end

	// ----------------------------------------------------------------
	// dma requests and interrupt events
	// ----------------------------------------------------------------

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			dma_seq_burst_req  <= 1'b0;
			dma_xseq_burst_req <= 1'b0;
		end else begin
			dma_seq_burst_req  <= seq_done;
			dma_xseq_burst_req <= xseq_done;
		end
	end

	// exceptional event pulses to the interrupt controller
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			irq_xseq <= 1'b0;
			irq_xint <= 1'b0;
		end else begin
			irq_xseq <= xseq_done;
			irq_xint <= xint_evt;
		end
	end

	// one request and one interrupt per channel
	generate
		for (genvar i = 0; i < AERL_NCH; i++) begin : g_ch
			always_ff @(posedge clock) begin
				if (!reset_n) begin
					dma_ch_req[i] <= 1'b0;
					irq_ch[i]     <= 1'b0;
				end else begin
					dma_ch_req[i] <= ch_evt[i];
					irq_ch[i]     <= ch_evt[i];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	logic [31:0] rd_word;   // word for the accepted read

	always_comb begin
		rd_word = AERL_ZERO_WORD;
		if (addr_is(a_addr, AERL_OFF_RESULT)) begin
			rd_word[AERL_VAL_W-1:0] = rif.value;
			rd_word[AERL_HOLD_BIT]  = rif.hold_sel;
			rd_word[AERL_VLD_BIT]   = rif.valid;
			rd_word[AERL_OVR_BIT]   = rif.overrun;
		end else if (addr_is(a_addr, AERL_OFF_STATUS)) begin
			rd_word[AERL_STS_W-1:0] = sts_q;
		end else begin
			// unmapped or clear register reads as zero
			rd_word = AERL_ZERO_WORD;
		end
	end

	// read data captured at the address phase edge, held afterwards
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			hrdata <= AERL_ZERO_WORD;
		end else if (rd_acc) begin
			hrdata <= rd_word;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_rd_clr;
		@(posedge clock) disable iff (!reset_n)
		rif.rd_clr && !res_wr |=> !rif.valid && !rif.overrun;
	endproperty
	a_rd_clr: assert property (p_rd_clr)
		else $error("result read did not clear flags");

	property p_fmt8;
		@(posedge clock) disable iff (!reset_n)
		res_wr && !res_10bit && !(rif.hold_sel && rif.valid)
			|=> rif.value == {$past(res_raw[7:0]), 4'h0};
	endproperty
	a_fmt8: assert property (p_fmt8)
		else $error("8-bit result misplaced");

	property p_fmt10;
		@(posedge clock) disable iff (!reset_n)
		res_wr && res_10bit && !(rif.hold_sel && rif.valid)
			|=> rif.value == {$past(res_raw), 2'h0};
	endproperty
	a_fmt10: assert property (p_fmt10)
		else $error("10-bit result misplaced");

	property p_rsvd;
		@(posedge clock) disable iff (!reset_n)
		hrdata[31:19] == 13'h0000 && hrdata[15:12] == 4'h0;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved read bits not zero");

	property p_ch_req;
		@(posedge clock) disable iff (!reset_n)
		!sw_mode |=> dma_ch_req == $past(ch_valid_set) &&
			irq_ch == $past(ch_valid_set) &&
			(sts_q[7:0] & $past(ch_valid_set)) == $past(ch_valid_set);
	endproperty
	a_ch_req: assert property (p_ch_req)
		else $error("channel request or status missing");

	property p_sw_quiet;
		@(posedge clock) disable iff (!reset_n)
		sw_mode |=> dma_ch_req == '0 && irq_ch == '0 && !irq_xint;
	endproperty
	a_sw_quiet: assert property (p_sw_quiet)
		else $error("valid event raised in software mode");

	property p_xseq;
		@(posedge clock) disable iff (!reset_n)
		xseq_done |=> dma_xseq_burst_req && irq_xseq &&
			sts_q[AERL_XSEQ_BIT];
	endproperty
	a_xseq: assert property (p_xseq)
		else $error("exceptional sequence event missing");

	property p_seq;
		@(posedge clock) disable iff (!reset_n)
		seq_done |=> dma_seq_burst_req ##1 !dma_seq_burst_req || $past(seq_done);
	endproperty
	a_seq: assert property (p_seq)
		else $error("sequence burst request missing");

	property p_xint;
		@(posedge clock) disable iff (!reset_n)
		rif.valid_rise && !sw_mode |=> irq_xint && sts_q[AERL_XINT_BIT];
	endproperty
	a_xint: assert property (p_xint)
		else $error("exceptional interrupt event missing");

	c_rd_result: cover property (@(posedge clock) disable iff (!reset_n)
		rif.valid ##1 rif.rd_clr ##1 !rif.valid);
	c_hold: cover property (@(posedge clock) disable iff (!reset_n)
		rif.hold_sel && rif.valid && res_wr);
	c_clear: cover property (@(posedge clock) disable iff (!reset_n)
		clr_wr && sts_q != '0);
endmodule : aerl_top

//--- rtl/aerl_pkg.sv
// constants shared by the exceptional result and event logic
// assumes a 32-bit word-addressed register bus and one system clock
package aerl_pkg;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0]  AERL_OFF_RESULT = 8'h40; // exceptional result
	localparam logic [7:0]  AERL_OFF_STATUS = 8'h78; // interrupt status word
	localparam logic [7:0]  AERL_OFF_CLEAR  = 8'h80; // status clear, w1c
	localparam int          AERL_ADDR_W     = 8;     // decoded address bits

	// ----------------------------------------------------------------
	// result register fields
	// ----------------------------------------------------------------
	localparam int          AERL_OVR_BIT    = 18;    // overrun flag
	localparam int          AERL_VLD_BIT    = 17;    // valid flag
	localparam int          AERL_HOLD_BIT   = 16;    // hold-until-read select
	localparam int          AERL_VAL_W      = 12;    // result value field
	localparam int          AERL_RAW_W      = 10;    // widest raw result
	localparam int          AERL_PAD8       = 4;     // zero pad, 8-bit mode
	localparam int          AERL_PAD10      = 2;     // zero pad, 10-bit mode
	localparam int          AERL_RAW8_W     = 8;     // 8-bit raw width
	localparam logic        AERL_HOLD_RST   = 1'b0;  // overwrite after reset

	// ----------------------------------------------------------------
	// interrupt status word fields
	// ----------------------------------------------------------------
	localparam int          AERL_NCH        = 8;     // conversion channels
	localparam int          AERL_XSEQ_BIT   = 9;     // exc sequence status
	localparam int          AERL_XINT_BIT   = 8;     // exc interrupt status
	localparam int          AERL_STS_W      = 10;    // used status bits

	// ----------------------------------------------------------------
	// bus encodings
	// ----------------------------------------------------------------
	localparam logic [2:0]  AERL_HSIZE_WORD = 3'h2;  // 32-bit transfer
	localparam logic        AERL_RESP_OKAY  = 1'b0;  // only response used
	localparam logic [31:0] AERL_ZERO_WORD  = 32'h0000_0000;

	// bus data phase state
	typedef enum logic [2:0] {
		AERL_PH_IDLE  = 3'b001, // no transfer pending
		AERL_PH_READ  = 3'b010, // read data phase
		AERL_PH_WRITE = 3'b100  // write data phase
	} aerl_phase_t;

endpackage : aerl_pkg

//--- rtl/aerl_res_if.sv
// carrier between the event logic and the exceptional result holder
// assumes both ends share the system clock
`timescale 1ns/100ps
interface aerl_res_if;
	import aerl_pkg::*;
	logic                  hw_wr;       // sequencer writes a result
	logic [AERL_VAL_W-1:0] hw_value;    // formatted result value
	logic                  repeats_done; // all repeat counts processed
	logic                  sw_mode;     // sequencer in software mode
	logic                  rd_clr;      // software read of the result
	logic                  sel_wr;      // software writes the hold select
	logic                  sel_val;     // hold select write data
	logic [AERL_VAL_W-1:0] value;       // stored result
	logic                  valid;       // valid flag
	logic                  overrun;     // overrun flag
	logic                  hold_sel;    // hold-until-read select
	logic                  valid_rise;  // valid becomes one at the next edge

	modport ctrl (output hw_wr, hw_value, repeats_done, sw_mode, rd_clr,
		sel_wr, sel_val, input value, valid, overrun, hold_sel, valid_rise);
	modport hold (input hw_wr, hw_value, repeats_done, sw_mode, rd_clr,
		sel_wr, sel_val, output value, valid, overrun, hold_sel, valid_rise);
endinterface : aerl_res_if

//--- rtl/aerl_result_hold.sv
// exceptional result holder: value, valid, overrun and hold select
// assumes strobes from the event logic are one-cycle pulses
`timescale 1ns/100ps
module aerl_result_hold
	import aerl_pkg::*;
(
	input  wire logic  clock,
	input  wire logic  reset_n,
	aerl_res_if.hold   rif
);
	import aerl_pkg::*;

	// ----------------------------------------------------------------
	// update decisions
	// ----------------------------------------------------------------
	logic store;    // new result is taken
	logic set_vld;  // valid flag set this cycle
	logic set_ovr;  // overrun flag set this cycle

	assign store   = rif.hw_wr && !(rif.hold_sel && rif.valid);
	assign set_vld = store && rif.repeats_done;
	assign set_ovr = store && rif.valid && !rif.hold_sel && !rif.sw_mode;

	// result value, kept until the next accepted write
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rif.value <= '0;
		end else if (store) begin
			rif.value <= rif.hw_value;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rif.valid <= 1'b0;
		end else if (set_vld) begin
			rif.valid <= 1'b1;
		end else if (rif.rd_clr) begin
			rif.valid <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rif.overrun <= 1'b0;
		end else if (set_ovr) begin
			rif.overrun <= 1'b1;
		end else if (rif.rd_clr) begin
			rif.overrun <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rif.hold_sel <= AERL_HOLD_RST;
		end else if (rif.sel_wr) begin
			rif.hold_sel <= rif.sel_val;
		end
	end

	// rising valid, only from a set while the flag was clear
	assign rif.valid_rise = set_vld && !rif.valid;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_ovr_set;
		@(posedge clock) disable iff (!reset_n)
		rif.hw_wr && rif.valid && !rif.hold_sel && !rif.sw_mode
			|=> rif.overrun;
	endproperty
	a_ovr_set: assert property (p_ovr_set)
		else $error("overrun not set on overwrite");

	property p_ovr_gate;
		@(posedge clock) disable iff (!reset_n)
		!rif.overrun && (rif.hold_sel || rif.sw_mode) |=> !rif.overrun;
	endproperty
	a_ovr_gate: assert property (p_ovr_gate)
		else $error("overrun set in hold or software mode");

	property p_hold_keep;
		@(posedge clock) disable iff (!reset_n)
		rif.hold_sel && rif.valid |=> $stable(rif.value);
	endproperty
	a_hold_keep: assert property (p_hold_keep)
		else $error("held result overwritten");

	property p_vld_repeat;
		@(posedge clock) disable iff (!reset_n)
		!rif.valid && !(rif.hw_wr && rif.repeats_done) |=> !rif.valid;
	endproperty
	a_vld_repeat: assert property (p_vld_repeat)
		else $error("valid set without completed repeats");

	c_overrun: cover property (@(posedge clock) disable iff (!reset_n)
		$rose(rif.overrun));
endmodule : aerl_result_hold

//--- sim/aerl_seq_model.sv
// sequencer model and request sink for the exceptional result logic
// assumes one system clock; drives its lines just after rising edges
`timescale 1ns/100ps
module aerl_seq_model
	import aerl_pkg::*;
(
	input  wire logic                  clock,
	output logic                       res_wr,
	output logic [AERL_RAW_W-1:0]      res_raw,
	output logic                       res_10bit,
	output logic                       repeats_done,
	output logic                       sw_mode,
	output logic                       seq_done,
	output logic                       xseq_done,
	output logic [AERL_NCH-1:0]        ch_valid_set,
	input  wire logic [19:0]           ev
);
	int cnt [20]; // cycles seen high, one per request or interrupt line

	// quiet sequencer from time zero
	initial begin
		res_wr = 1'b0;
		res_raw = '0;
		res_10bit = 1'b0;
		repeats_done = 1'b0;
		sw_mode = 1'b0;
		{seq_done, xseq_done, ch_valid_set} = '0;
	end

	// counting cycles rather than edges also catches pulses that stretch
	always @(posedge clock) begin
		for (int i = 0; i < 20; i++) begin
			cnt[i] <= cnt[i] + int'(ev[i]);
		end
	end

	// one result word, format and repeat state qualify the strobe
	task automatic put_result(input logic [AERL_RAW_W-1:0] raw,
		input logic ten, input logic rep);
		@(posedge clock);
		res_wr <= 1'b1;
		res_raw <= raw;
		res_10bit <= ten;
		repeats_done <= rep;
		@(posedge clock);
		res_wr <= 1'b0;
		res_raw <= ~raw; // stale data inverted so a late sample shows
		repeats_done <= ~rep;
	endtask

	// one-cycle pulse of {seq_done, xseq_done, ch_valid_set}
	task automatic pulse_evt(input logic [AERL_NCH+1:0] m);
		@(posedge clock);
		{seq_done, xseq_done, ch_valid_set} <= m;
		@(posedge clock);
		{seq_done, xseq_done, ch_valid_set} <= '0;
	endtask

	// sequencer mode level
	task automatic set_sw(input logic v);
		@(posedge clock);
		sw_mode <= v;
	endtask
endmodule // aerl_seq_model

//--- sim/aerl_top_test.sv
// self-checking bench for the exceptional result and event logic
// assumes zero-wait AHB-Lite slave and the sequencer model beside it
`timescale 1ns/100ps
module aerl_top_test;
	import aerl_pkg::*;
	logic        clock, reset_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        res_wr, res_10bit, repeats_done, sw_mode;
	logic        seq_done, xseq_done, irq_xseq, irq_xint;
	logic [9:0]  res_raw;
	logic [7:0]  ch_valid_set, dma_ch_req, irq_ch;
	logic        dma_seq_burst_req, dma_xseq_burst_req;
	logic [2:0]  sz; // transfer size the master puts on hsize
	int          miscompares, n_tests;
	int          ex [20]; // expected high cycles per event line

	aerl_top u_aerl_top (.clock(clock), .reset_n(reset_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .res_wr(res_wr), .res_raw(res_raw),
		.res_10bit(res_10bit), .repeats_done(repeats_done),
		.sw_mode(sw_mode), .seq_done(seq_done), .xseq_done(xseq_done),
		.ch_valid_set(ch_valid_set),
		.dma_seq_burst_req(dma_seq_burst_req),
		.dma_xseq_burst_req(dma_xseq_burst_req), .dma_ch_req(dma_ch_req),
		.irq_xseq(irq_xseq), .irq_xint(irq_xint), .irq_ch(irq_ch));
	aerl_seq_model u_aerl_seq_model (.clock(clock), .res_wr(res_wr),
		.res_raw(res_raw), .res_10bit(res_10bit),
		.repeats_done(repeats_done), .sw_mode(sw_mode),
		.seq_done(seq_done), .xseq_done(xseq_done),
		.ch_valid_set(ch_valid_set), .ev({dma_seq_burst_req,
		dma_xseq_burst_req, irq_xseq, irq_xint, dma_ch_req, irq_ch}));

	// ----------------------------------------------------------------
	// clock, closing and comparisons
	// ----------------------------------------------------------------
	initial clock = 1'b0;
	always #4 clock = ~clock;

	task automatic stop_test;
		$display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: expected %08h got %08h",
				$time, exp, got);
		end
	endtask

	// settle three cycles so registered pulses have been counted
	task automatic check_counts;
		repeat (3) @(posedge clock);
		for (int i = 0; i < 20; i++) begin
			n_tests++;
			if (u_aerl_seq_model.cnt[i] != ex[i]) begin
				miscompares++;
				$display("CHECK FAILED at %0t: line %0d expected %08h got %08h",
					$time, i, ex[i], u_aerl_seq_model.cnt[i]);
			end
		end
	endtask

	// ----------------------------------------------------------------
	// bus master: single transfers of size sz, whole words by default, waits on hready
	// ----------------------------------------------------------------
	task automatic ahb(input logic wr, input logic [31:0] addr,
		input logic [31:0] wdata, output logic [31:0] rdata);
		int n;
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= addr;
		hwrite <= wr;
		// whole words unless a refusal is probed
		hsize <= sz;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wdata;
		do begin
			@(posedge clock);
			n++;
		end while (hreadyout !== 1'b1 && n < 200);
		rdata = hrdata;
		if (n >= 100) miscompares++;
		check_word(32'(AERL_RESP_OKAY), 32'(hresp));
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'b0, 32'(a), 32'h0000_0000, d);
		check_word(exp, d);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		logic [31:0] d;
		ahb(1'b1, 32'(a), w, d);
	endtask

	// watchdog at 12500 cycles, well beyond the roughly 120 cycles the tests need
	initial begin
		#100000;
		miscompares++;
		stop_test;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{reset_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = AERL_HSIZE_WORD;
		sz = AERL_HSIZE_WORD;
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		rd(AERL_OFF_RESULT, 32'h0000_0000);
		rd(AERL_OFF_STATUS, 32'h0000_0000);
		rd(8'h10, 32'h0000_0000);
		// formats, valid set and read clear
		u_aerl_seq_model.put_result(10'h3A5, 1'b0, 1'b1);
		ex[16]++;
		rd(AERL_OFF_RESULT, 32'h0002_0A50);
		rd(AERL_OFF_RESULT, 32'h0000_0A50);
		u_aerl_seq_model.put_result(10'h155, 1'b1, 1'b0);
		rd(AERL_OFF_RESULT, 32'h0000_0554);
		// overwrite of an unread result
		u_aerl_seq_model.put_result(10'h3FF, 1'b1, 1'b1);
		u_aerl_seq_model.put_result(10'h001, 1'b1, 1'b1);
		ex[16]++;
		rd(AERL_OFF_RESULT, 32'h0006_0004);
		rd(AERL_OFF_RESULT, 32'h0000_0004);
		wr(AERL_OFF_RESULT, 32'hFFFF_FFFF);
		rd(AERL_OFF_RESULT, 32'h0001_0004);
		// hold mode keeps the unread word
		u_aerl_seq_model.put_result(10'h0AA, 1'b0, 1'b1);
		u_aerl_seq_model.put_result(10'h055, 1'b0, 1'b1);
		ex[16]++;
		rd(AERL_OFF_RESULT, 32'h0003_0AA0);
		u_aerl_seq_model.put_result(10'h055, 1'b0, 1'b1);
		ex[16]++;
		rd(AERL_OFF_RESULT, 32'h0003_0550);
		wr(AERL_OFF_RESULT, 32'h0000_0000);
		rd(AERL_OFF_RESULT, 32'h0000_0550);
		// software mode: valid flag moves, overrun stays clear, no valid-driven events
		u_aerl_seq_model.set_sw(1'b1);
		u_aerl_seq_model.put_result(10'h011, 1'b0, 1'b1);
		u_aerl_seq_model.put_result(10'h022, 1'b0, 1'b1);
		rd(AERL_OFF_RESULT, 32'h0002_0220);
		u_aerl_seq_model.pulse_evt(10'h0FF);
		u_aerl_seq_model.set_sw(1'b0);
		check_counts;
		// sequence, exceptional and channel events
		u_aerl_seq_model.pulse_evt(10'h200);
		ex[19]++;
		u_aerl_seq_model.pulse_evt(10'h100);
		ex[18]++;
		ex[17]++;
		for (int i = 0; i < 8; i++) begin
			u_aerl_seq_model.pulse_evt(10'(1 << i));
			ex[8+i]++;
			ex[i]++;
		end
		check_counts;
		rd(AERL_OFF_STATUS, 32'h0000_03FF);
		wr(AERL_OFF_CLEAR, 32'hFFFF_FFFF);
		rd(AERL_OFF_STATUS, 32'h0000_0000);
		rd(AERL_OFF_CLEAR, 32'h0000_0000);
		// a byte-sized write is refused, the hold select stays clear
		sz = 3'h0;
		wr(AERL_OFF_RESULT, 32'hFFFF_FFFF);
		sz = AERL_HSIZE_WORD;
		rd(AERL_OFF_RESULT, 32'h0000_0220);
		stop_test;
	end
endmodule // aerl_top_test
